// file: design/bpe_handler.sv
// Program/erase state command interpreter for the boot-mode flash loader.
// Assumes a byte link (valid/ready both ways) and a flash back end that
// completes one operation per cycle in which request and acknowledge are high.
module bpe_handler import bpe_pkg::*; #(
  parameter logic [31:0] BOOT_SIZE  = 32'h0000_8000,
  parameter logic [31:0] USER_SIZE  = 32'h0004_0000,
  parameter logic [7:0]  NUM_BLOCKS = 8'h10
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  output logic             fl_req_o,
  output bpe_op_t          fl_op_o,
  output logic             fl_area_o,
  output logic      [31:0] fl_addr_o,
  output logic      [7:0]  fl_wdata_o,
  output logic      [7:0]  fl_block_o,
  input  wire logic        fl_ack_i,
  input  wire logic        fl_err_i,
  input  wire logic [7:0]  fl_rdata_i
);
  typedef enum logic [3:0] {
    S_CMD   = 4'h0,
    S_RX    = 4'h1,
    S_CHK   = 4'h2,
    S_LOAD  = 4'h3,
    S_PROG  = 4'h4,
    S_ERASE = 4'h5,
    S_SCAN  = 4'h6,
    S_RDREQ = 4'h7,
    S_RDTX  = 4'h8,
    S_TX    = 4'h9
  } bpe_fsm_t;

  typedef struct packed {
    bpe_fsm_t          fsm;
    bpe_fsm_t          after;
    bpe_mode_t         mode;
    logic              errf;
    logic              sel_user;
    logic [7:0]        cmd;
    logic [7:0]        need;
    logic [7:0]        cnt;
    logic [10:0][7:0]  hdr;
    logic [127:0][7:0] dbuf;
    logic [31:0]       addr;
    logic [31:0]       rem;
    logic [31:0]       sum32;
    logic              blank;
    logic              area;
    logic [5:0][7:0]   txb;
    logic [2:0]        tlen;
    logic [2:0]        tidx;
    logic              wsum;
    logic              tclr;
    logic              tv;
    logic [7:0]        td;
  } bpe_st_t;

  bpe_st_t     r;
  bpe_st_t     n;
  logic        rx_fire;
  logic        tx_fire;
  logic [7:0]  rx_sum;
  logic [7:0]  tx_sum;
  logic        chk_area;
  logic [31:0] chk_addr;
  logic [31:0] chk_len;
  logic        start_bad;
  logic        end_bad;
  logic        align_bad;
  logic        sum_ok;
  logic [7:0]  status;

  // Start a reply with its first two fixed bytes; errors latch the sticky flag
  function automatic bpe_st_t rep(input bpe_st_t s, input logic [7:0] b0,
                                  input logic [7:0] b1, input logic [2:0] len,
                                  input logic e);
    rep        = s;
    rep.txb[0] = b0;
    rep.txb[1] = b1;
    rep.tlen   = len;
    rep.tidx   = '0;
    rep.wsum   = 1'b0;
    rep.tclr   = 1'b1;
    rep.fsm    = S_TX;
    rep.after  = S_CMD;
    rep.errf   = s.errf | e;
  endfunction

  // Link handshakes; no byte is taken while a reply is pending
  assign rx_ready_o = (r.fsm == S_CMD) || (r.fsm == S_RX);
  assign rx_fire    = rx_valid_i && rx_ready_o;
  assign tx_fire    = r.tv && tx_ready_i;
  assign tx_valid_o = r.tv;
  assign tx_data_o  = r.td;

  // Receive checksum restarts on every command byte
  bpe_sum8 u_rx_sum (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (r.fsm == S_CMD),
    .add_i   (rx_fire),
    .byte_i  (rx_data_i),
    .sum_o   (rx_sum)
  );

  // Transmit checksum covers every byte handed out since the reply began
  bpe_sum8 u_tx_sum (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (r.tclr),
    .add_i   (tx_fire),
    .byte_i  (r.td),
    .sum_o   (tx_sum)
  );

  // Read frames check their own area and span; program frames a full unit
  assign chk_area = (r.cmd == CMD_READ) ? r.hdr[1][0] : r.sel_user;
  assign chk_addr = (r.cmd == CMD_READ) ? {r.hdr[2], r.hdr[3], r.hdr[4], r.hdr[5]}
                                        : {r.hdr[0], r.hdr[1], r.hdr[2], r.hdr[3]};
  assign chk_len  = (r.cmd == CMD_READ) ? {r.hdr[6], r.hdr[7], r.hdr[8], r.hdr[9]}
                                        : PROG_UNIT;

  bpe_range #(
    .BOOT_SIZE (BOOT_SIZE),
    .USER_SIZE (USER_SIZE)
  ) u_range (
    .area_i      (chk_area),
    .addr_i      (chk_addr),
    .len_i       (chk_len),
    .start_bad_o (start_bad),
    .end_bad_o   (end_bad),
    .align_bad_o (align_bad)
  );

  assign sum_ok = rx_sum == BYTE_ZERO;

  // Waiting state reported by the status inquiry
  always_comb begin
    unique case (r.mode)
      MODE_PROG:  status = STAT_PROG;
      MODE_ERASE: status = STAT_ERASE;
      default:    status = STAT_SEL;
    endcase
  end

  // Flash request; held until the back end acknowledges
  always_comb begin
    fl_req_o = 1'b0;
    fl_op_o  = OP_NONE;
    unique case (r.fsm)
      S_LOAD: begin
        fl_req_o = 1'b1;
        fl_op_o  = (r.cmd == CMD_SEL_ERASE) ? OP_LOAD_ERASE : OP_LOAD_PROG;
      end
      S_PROG: begin
        fl_req_o = 1'b1;
        fl_op_o  = OP_WRITE;
      end
      S_ERASE: begin
        fl_req_o = 1'b1;
        fl_op_o  = OP_ERASE;
      end
      S_SCAN, S_RDREQ: begin
        fl_req_o = r.rem != '0;
        fl_op_o  = OP_READ;
      end
      default: begin
        fl_req_o = 1'b0;
        fl_op_o  = OP_NONE;
      end
    endcase
  end

  assign fl_area_o  = r.area;
  assign fl_addr_o  = r.addr;
  assign fl_wdata_o = r.dbuf[r.cnt[6:0]];
  assign fl_block_o = r.hdr[1];

  // Command sequencer
  always_comb begin
    n      = r;
    n.tclr = 1'b0;
    unique case (r.fsm)
      S_CMD: begin
        if (rx_fire) begin
          n.cmd = rx_data_i;
          n.cnt = '0;
          case (rx_data_i)
            CMD_STATUS: begin
              n        = rep(r, RSP_STATUS, SIZE_STAT, LEN_STAT, 1'b0);
              n.txb[2] = status;
              n.txb[3] = {7'h00, r.errf};
              n.wsum   = 1'b1;
            end
            CMD_SEL_BOOT, CMD_SEL_USER, CMD_SEL_ERASE: begin
              n.sel_user = rx_data_i == CMD_SEL_USER;
              n.area     = rx_data_i == CMD_SEL_USER;
              n.fsm      = S_LOAD;
              if (r.mode != MODE_SEL) begin
                n = rep(r, RSP_CMDERR, rx_data_i, LEN_TWO, 1'b1);
              end
            end
            CMD_PROG: begin
              n.need = NEED_PROG_ADDR;
              n.fsm  = S_RX;
              if (r.mode != MODE_PROG) begin
                n = rep(r, RSP_CMDERR, rx_data_i, LEN_TWO, 1'b1);
              end
            end
            CMD_ERASE: begin
              n.need = NEED_ERASE;
              n.fsm  = S_RX;
              if (r.mode != MODE_ERASE) begin
                n = rep(r, RSP_CMDERR, rx_data_i, LEN_TWO, 1'b1);
              end
            end
            CMD_READ: begin
              n.need = NEED_READ;
              n.fsm  = S_RX;
            end
            CMD_BSUM, CMD_USUM, CMD_BBLANK, CMD_UBLANK: begin
              n.area  = (rx_data_i == CMD_USUM) || (rx_data_i == CMD_UBLANK);
              n.rem   = n.area ? USER_SIZE : BOOT_SIZE;
              n.addr  = '0;
              n.sum32 = '0;
              n.blank = 1'b1;
              n.fsm   = S_SCAN;
            end
            default: n = rep(r, RSP_CMDERR, rx_data_i, LEN_TWO, 1'b1);
          endcase
        end
      end
      S_RX: begin
        if (rx_fire) begin
          if (r.cnt < HDR_LEN) begin
            n.hdr[r.cnt[3:0]] = rx_data_i;
          end
          if (r.cmd == CMD_PROG && r.cnt >= DATA_OFS && r.cnt < NEED_PROG_FULL - 8'h01) begin
            n.dbuf[7'(r.cnt - DATA_OFS)] = rx_data_i;
          end
          n.cnt = r.cnt + 8'h01;
          if (r.cmd == CMD_PROG && r.cnt == NEED_PROG_ADDR - 8'h01) begin
            // Stop code carries no data bytes, only the checksum
            n.need = ({r.hdr[0], r.hdr[1], r.hdr[2], rx_data_i} == ADDR_END)
                     ? NEED_PROG_END : NEED_PROG_FULL;
          end else if (r.cnt + 8'h01 == r.need) begin
            n.fsm = S_CHK;
          end
        end
      end
      S_CHK: begin
        if (r.cmd == CMD_PROG) begin
          if (!sum_ok) begin
            n = rep(r, RSP_PROG, ERR_SUM, LEN_TWO, 1'b1);
          end else if (r.need == NEED_PROG_END) begin
            n      = rep(r, RSP_ACK, RSP_ACK, LEN_ONE, 1'b0);
            n.mode = MODE_SEL;
          end else if (align_bad || end_bad || start_bad) begin
            n = rep(r, RSP_PROG, ERR_ADDR, LEN_TWO, 1'b1);
          end else begin
            n.addr = chk_addr;
            n.area = r.sel_user;
            n.cnt  = '0;
            n.fsm  = S_PROG;
          end
        end else if (r.cmd == CMD_ERASE) begin
          if (!sum_ok) begin
            n = rep(r, RSP_ERASE, ERR_SUM, LEN_TWO, 1'b1);
          end else if (r.hdr[0] != SIZE_ERASE) begin
            n = rep(r, RSP_ERASE, ERR_BLOCK, LEN_TWO, 1'b1);
          end else if (r.hdr[1] == BYTE_FF) begin
            n      = rep(r, RSP_ACK, RSP_ACK, LEN_ONE, 1'b0);
            n.mode = MODE_SEL;
          end else if (r.hdr[1] >= NUM_BLOCKS) begin
            n = rep(r, RSP_ERASE, ERR_BLOCK, LEN_TWO, 1'b1);
          end else begin
            n.fsm = S_ERASE;
          end
        end else begin
          if (!sum_ok) begin
            n = rep(r, RSP_READ, ERR_SUM, LEN_TWO, 1'b1);
          end else if (r.hdr[0] != SIZE_READ || r.hdr[1] > AREA_MAX || start_bad) begin
            n = rep(r, RSP_READ, ERR_ADDR, LEN_TWO, 1'b1);
          end else if (end_bad) begin
            n = rep(r, RSP_READ, ERR_LEN, LEN_TWO, 1'b1);
          end else begin
            n        = rep(r, CMD_READ, r.hdr[6], LEN_RDH, 1'b0);
            n.txb[2] = r.hdr[7];
            n.txb[3] = r.hdr[8];
            n.txb[4] = r.hdr[9];
            n.after  = S_RDREQ;
            n.addr   = chk_addr;
            n.rem    = chk_len;
            n.area   = chk_area;
          end
        end
      end
      S_LOAD: begin
        if (fl_ack_i) begin
          if (fl_err_i) begin
            n = rep(r, (r.cmd == CMD_SEL_ERASE) ? RSP_SELE :
                       (r.cmd == CMD_SEL_USER) ? RSP_SELU : RSP_SELB,
                    ERR_SELECT, LEN_TWO, 1'b1);
          end else begin
            n      = rep(r, RSP_ACK, RSP_ACK, LEN_ONE, 1'b0);
            n.mode = (r.cmd == CMD_SEL_ERASE) ? MODE_ERASE : MODE_PROG;
          end
        end
      end
      S_PROG: begin
        if (fl_ack_i) begin
          if (fl_err_i) begin
            // Programming cannot go on; fall back to selection wait
            n      = rep(r, RSP_PROG, ERR_PROG, LEN_TWO, 1'b1);
            n.mode = MODE_SEL;
          end else if (r.cnt == PROG_LAST) begin
            n = rep(r, RSP_ACK, RSP_ACK, LEN_ONE, 1'b0);
          end else begin
            n.cnt  = r.cnt + 8'h01;
            n.addr = r.addr + 32'h0000_0001;
          end
        end
      end
      S_ERASE: begin
        if (fl_ack_i) begin
          if (fl_err_i) begin
            n = rep(r, RSP_ERASE, ERR_ERASE, LEN_TWO, 1'b1);
          end else begin
            n = rep(r, RSP_ACK, RSP_ACK, LEN_ONE, 1'b0);
          end
        end
      end
      S_SCAN: begin
        if (r.rem == '0) begin
          if (r.cmd == CMD_BSUM || r.cmd == CMD_USUM) begin
            n = rep(r, (r.cmd == CMD_USUM) ? RSP_USUM : RSP_BSUM, SIZE_SUM,
                    LEN_SUMR, 1'b0);
            n.txb[2] = r.sum32[31:24];
            n.txb[3] = r.sum32[23:16];
            n.txb[4] = r.sum32[15:8];
            n.txb[5] = r.sum32[7:0];
            n.wsum   = 1'b1;
          end else if (r.blank) begin
            n = rep(r, RSP_ACK, RSP_ACK, LEN_ONE, 1'b0);
          end else begin
            n = rep(r, (r.cmd == CMD_UBLANK) ? RSP_UBLANK : RSP_BBLANK, ERR_BLANK,
                    LEN_TWO, 1'b1);
          end
        end else if (fl_ack_i) begin
          n.sum32 = r.sum32 + {24'h000000, fl_rdata_i};
          n.blank = r.blank && (fl_rdata_i == BYTE_FF);
          n.addr  = r.addr + 32'h0000_0001;
          n.rem   = r.rem - 32'h0000_0001;
        end
      end
      S_RDREQ: begin
        if (r.rem == '0) begin
          // Only the trailing checksum is left to send
          n.tlen  = '0;
          n.tidx  = '0;
          n.wsum  = 1'b1;
          n.after = S_CMD;
          n.fsm   = S_TX;
        end else if (fl_ack_i) begin
          n.tv   = 1'b1;
          n.td   = fl_rdata_i;
          n.addr = r.addr + 32'h0000_0001;
          n.rem  = r.rem - 32'h0000_0001;
          n.fsm  = S_RDTX;
        end
      end
      S_RDTX: begin
        if (tx_fire) begin
          n.tv  = 1'b0;
          n.fsm = S_RDREQ;
        end
      end
      S_TX: begin
        if (r.tv) begin
          if (tx_ready_i) begin
            n.tv   = 1'b0;
            n.tidx = r.tidx + 3'h1;
          end
        end else if (r.tidx < r.tlen) begin
          n.tv = 1'b1;
          n.td = r.txb[r.tidx];
        end else if (r.wsum) begin
          n.tv   = 1'b1;
          n.td   = BYTE_ZERO - tx_sum;
          n.wsum = 1'b0;
        end else begin
          n.fsm = r.after;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// file: design/bpe_range.sv
// Address, length and alignment checks against the selected array.
// Purely combinational; inputs come from registers of the handler.
module bpe_range import bpe_pkg::*; #(
  parameter logic [31:0] BOOT_SIZE = 32'h0000_8000,
  parameter logic [31:0] USER_SIZE = 32'h0004_0000
) (
  input  wire logic        area_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] len_i,
  output logic             start_bad_o,
  output logic             end_bad_o,
  output logic             align_bad_o
);
  logic [31:0] limit;
  logic [32:0] span_end;

  // Wide sum so a huge length cannot wrap past the limit
  assign limit       = area_i ? USER_SIZE : BOOT_SIZE;
  assign span_end    = {1'b0, addr_i} + {1'b0, len_i};
  assign start_bad_o = addr_i >= limit;
  assign end_bad_o   = span_end > {1'b0, limit};
  assign align_bad_o = (addr_i & ALIGN_MASK) != '0;
endmodule

// file: design/bpe_sum8.sv
// Running eight-bit sum of a byte stream, used for frame checksums.
// Assumes clear and add are driven from logic on the same clock.
module bpe_sum8 import bpe_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clr_i,
  input  wire logic       add_i,
  input  wire logic [7:0] byte_i,
  output logic      [7:0] sum_o
);
  typedef struct packed {
    logic [7:0] sum;
  } bpe_sum_t;

  bpe_sum_t r;
  bpe_sum_t n;

  // Clear may coincide with the first byte of a frame
  always_comb begin
    n = r;
    if (clr_i) begin
      n.sum = add_i ? byte_i : BYTE_ZERO;
    end else if (add_i) begin
      n.sum = r.sum + byte_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sum_o = r.sum;
endmodule

// file: inc/bpe_pkg.sv
// Constants, encodings and shared types for the program/erase command handler.
// Assumes a byte stream link in front of it and a flash back end behind it.
package bpe_pkg;
  // Command codes
  localparam logic [7:0] CMD_SEL_BOOT  = 8'h42;
  localparam logic [7:0] CMD_SEL_USER  = 8'h43;
  localparam logic [7:0] CMD_SEL_ERASE = 8'h48;
  localparam logic [7:0] CMD_BSUM      = 8'h4A;
  localparam logic [7:0] CMD_USUM      = 8'h4B;
  localparam logic [7:0] CMD_BBLANK    = 8'h4C;
  localparam logic [7:0] CMD_UBLANK    = 8'h4D;
  localparam logic [7:0] CMD_STATUS    = 8'h4F;
  localparam logic [7:0] CMD_PROG      = 8'h50;
  localparam logic [7:0] CMD_READ      = 8'h52;
  localparam logic [7:0] CMD_ERASE     = 8'h58;
  // Reply heads
  localparam logic [7:0] RSP_ACK    = 8'h06;
  localparam logic [7:0] RSP_CMDERR = 8'h80;
  localparam logic [7:0] RSP_SELB   = 8'hC2;
  localparam logic [7:0] RSP_SELU   = 8'hC3;
  localparam logic [7:0] RSP_SELE   = 8'hC8;
  localparam logic [7:0] RSP_BBLANK = 8'hCC;
  localparam logic [7:0] RSP_UBLANK = 8'hCD;
  localparam logic [7:0] RSP_PROG   = 8'hD0;
  localparam logic [7:0] RSP_READ   = 8'hD2;
  localparam logic [7:0] RSP_ERASE  = 8'hD8;
  localparam logic [7:0] RSP_BSUM   = 8'h5A;
  localparam logic [7:0] RSP_USUM   = 8'h5B;
  localparam logic [7:0] RSP_STATUS = 8'h5F;
  // Error codes
  localparam logic [7:0] ERR_SUM    = 8'h11;
  localparam logic [7:0] ERR_BLOCK  = 8'h29;
  localparam logic [7:0] ERR_ADDR   = 8'h2A;
  localparam logic [7:0] ERR_LEN    = 8'h2B;
  localparam logic [7:0] ERR_ERASE  = 8'h51;
  localparam logic [7:0] ERR_BLANK  = 8'h52;
  localparam logic [7:0] ERR_PROG   = 8'h53;
  localparam logic [7:0] ERR_SELECT = 8'h54;
  // Status codes
  localparam logic [7:0] STAT_SEL   = 8'h3F;
  localparam logic [7:0] STAT_PROG  = 8'h4F;
  localparam logic [7:0] STAT_ERASE = 8'h5F;
  // Frame sizes and byte counts after the command byte
  localparam logic [7:0]  SIZE_ERASE     = 8'h01;
  localparam logic [7:0]  SIZE_READ      = 8'h09;
  localparam logic [7:0]  SIZE_SUM       = 8'h04;
  localparam logic [7:0]  SIZE_STAT      = 8'h02;
  localparam logic [7:0]  NEED_PROG_ADDR = 8'h04;
  localparam logic [7:0]  NEED_PROG_END  = 8'h05;
  localparam logic [7:0]  NEED_PROG_FULL = 8'h85;
  localparam logic [7:0]  NEED_ERASE     = 8'h03;
  localparam logic [7:0]  NEED_READ      = 8'h0B;
  localparam logic [7:0]  DATA_OFS       = 8'h04;
  localparam logic [7:0]  HDR_LEN        = 8'h0B;
  localparam logic [7:0]  PROG_LAST      = 8'h7F;
  localparam logic [31:0] PROG_UNIT      = 32'h0000_0080;
  localparam logic [31:0] ALIGN_MASK     = 32'h0000_007F;
  localparam logic [31:0] ADDR_END       = 32'hFFFF_FFFF;
  localparam logic [7:0]  BYTE_FF        = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [7:0]  AREA_MAX       = 8'h01;
  // Reply lengths before the optional checksum
  localparam logic [2:0] LEN_ONE  = 3'h1;
  localparam logic [2:0] LEN_TWO  = 3'h2;
  localparam logic [2:0] LEN_STAT = 3'h4;
  localparam logic [2:0] LEN_SUMR = 3'h6;
  localparam logic [2:0] LEN_RDH  = 3'h5;

  typedef enum logic [1:0] {
    MODE_SEL   = 2'h0,
    MODE_PROG  = 2'h1,
    MODE_ERASE = 2'h2
  } bpe_mode_t;

  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_LOAD_PROG  = 3'h1,
    OP_LOAD_ERASE = 3'h2,
    OP_WRITE      = 3'h3,
    OP_ERASE      = 3'h4,
    OP_READ       = 3'h5
  } bpe_op_t;
endpackage

// file: tb/bpe_chk.sv
// Port checker for bpe_handler, bound from tb_top.
// Assumes one clock and the asynchronous active-low reset.
module bpe_chk import bpe_pkg::*; #(
  parameter logic [31:0] BOOT_SIZE  = 32'h10,
  parameter logic [31:0] USER_SIZE  = 32'h100,
  parameter logic [7:0]  NUM_BLOCKS = 8'h10
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        rx_ready_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_ready_i,
  input wire logic        fl_req_o,
  input wire bpe_op_t     fl_op_o,
  input wire logic        fl_area_o,
  input wire logic [31:0] fl_addr_o,
  input wire logic [7:0]  fl_block_o,
  input wire logic        fl_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Unanswered requests must stand still
  sequence s_txw; tx_valid_o && !tx_ready_i; endsequence
  sequence s_wr; fl_req_o && fl_op_o == OP_WRITE; endsequence
  property p_txh; s_txw |=> tx_valid_o && $stable(tx_data_o); endproperty
  a_txh: assert property (p_txh) else $error("reply not held");
  property p_gap; tx_valid_o && tx_ready_i |=> !tx_valid_o; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle");
  property p_half; tx_valid_o |-> !rx_ready_o; endproperty
  a_half: assert property (p_half) else $error("rx open in reply");
  property p_flh; fl_req_o && !fl_ack_i |=> fl_req_o && $stable(fl_addr_o); endproperty
  a_flh: assert property (p_flh) else $error("flash req moved");
  property p_blk; fl_req_o && fl_op_o == OP_ERASE |-> fl_block_o < NUM_BLOCKS; endproperty
  a_blk: assert property (p_blk) else $error("bad block erased");
  property p_rng; fl_req_o && fl_op_o inside {OP_WRITE, OP_READ}
    |-> fl_addr_o < (fl_area_o ? USER_SIZE : BOOT_SIZE); endproperty
  a_rng: assert property (p_rng) else $error("outside array");
  property p_inc; s_wr ##0 fl_ack_i ##1 s_wr |-> fl_addr_o == $past(fl_addr_o) + 32'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("write skipped");
  property p_aln; $rose(fl_req_o) && fl_op_o == OP_WRITE |-> fl_addr_o[6:0] == 7'h00;
  endproperty
  a_aln: assert property (p_aln) else $error("unaligned write");
endmodule

// file: tb/bpe_flash_model.sv
// Flash back end model: two 256-byte arrays, ack on alternate cycles.
// Fault injection comes from the bench; erase contents are not kept.
module bpe_flash_model import bpe_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire bpe_op_t     op_i,
  input  wire logic        area_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        err_en_i,
  output logic             ack_o,
  output logic             err_o,
  output logic      [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [2][256];
  logic       slow = 1'b0;
  // Alternate ack gives both waits and back-to-back ops
  assign ack_o   = req_i & slow;
  assign err_o   = ack_o & err_en_i;
  // Off-ack data inverted so a stale sample cannot pass
  assign rdata_o = mem[area_i][addr_i[7:0]] ^ {8{~ack_o}};
  initial foreach (mem[a, i]) mem[a][i] = 8'hFF;
  always @(posedge clk_i) begin
    slow <= ~slow;
    if (ack_o && op_i == OP_WRITE) mem[area_i][addr_i[7:0]] <= wdata_i;
  end
endmodule

// file: tb/tb_top.sv
// Bench: drives bpe_handler as the host and judges each reply.
// Flash is bpe_flash_model; arrays shrunk to 16 and 256 bytes.
module tb_top import bpe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bpe_q_t[$];
  logic        clk, rst_n, rxv, rxr, txv, txr, req, area, ack, ferr, fe;
  logic [7:0]  rxd, txd, wd, rd;
  logic [31:0] addr;
  bpe_op_t     op;
  int          err_count, total_checks;
  bpe_handler #(.BOOT_SIZE(32'h10), .USER_SIZE(32'h100)) uut (.clk_i(clk), .rst_n_i(rst_n),
    .rx_valid_i(rxv), .rx_data_i(rxd), .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd),
    .tx_ready_i(txr), .fl_req_o(req), .fl_op_o(op), .fl_area_o(area), .fl_addr_o(addr),
    .fl_wdata_o(wd), .fl_block_o(), .fl_ack_i(ack), .fl_err_i(ferr), .fl_rdata_i(rd));
  bpe_flash_model fm (.clk_i(clk), .req_i(req), .op_i(op), .area_i(area), .addr_i(addr),
    .wdata_i(wd), .err_en_i(fe), .ack_o(ack), .err_o(ferr), .rdata_o(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Run is a few thousand cycles; 50k means a hang
  initial begin
    #500000;
    err_count++;
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic bpe_q_t wc(bpe_q_t q);
    logic [7:0] s = 8'h00;
    foreach (q[i]) s += q[i];
    q.push_back(8'h00 - s);
    return q;
  endfunction
  function automatic bpe_q_t rdf(logic [7:0] a, logic [31:0] s, logic [31:0] n);
    return wc({CMD_READ, SIZE_READ, a, s[31:24], s[23:16], s[15:8], s[7:0],
      n[31:24], n[23:16], n[15:8], n[7:0]});
  endfunction
  // Send a frame held until taken; stall each reply byte one edge so holding is seen
  task automatic xf(bpe_q_t f, bpe_q_t e);
    foreach (f[i]) begin
      rxv = 1'b1;
      rxd = f[i];
      do @(posedge clk); while (rxr !== 1'b1);
      #1;
    end
    rxv = 1'b0;
    foreach (e[i]) begin
      do @(posedge clk); while (txv !== 1'b1);
      #1 txr = 1'b1;
      @(posedge clk);
      chk("reply", txd, e[i]);
      #1 txr = 1'b0;
    end
  endtask
  task automatic st(logic [7:0] s, logic [7:0] e);
    xf({CMD_STATUS}, wc({RSP_STATUS, SIZE_STAT, s, e}));
  endtask
  task automatic t_idle();
    st(STAT_SEL, 8'h00);
    xf({CMD_BBLANK}, {RSP_ACK});
    xf({CMD_BSUM}, wc({RSP_BSUM, SIZE_SUM, 8'h00, 8'h00, 8'h0F, 8'hF0}));
  endtask
  task automatic t_erase();
    xf({CMD_ERASE}, {RSP_CMDERR, CMD_ERASE});
    st(STAT_SEL, 8'h01);
    xf({CMD_SEL_ERASE}, {RSP_ACK});
    st(STAT_ERASE, 8'h01);
    xf(wc({CMD_ERASE, SIZE_ERASE, 8'h0F}), {RSP_ACK});
    xf({CMD_ERASE, SIZE_ERASE, 8'h03, 8'h00}, {RSP_ERASE, ERR_SUM});
    xf(wc({CMD_ERASE, SIZE_ERASE, 8'h10}), {RSP_ERASE, ERR_BLOCK});
    xf(wc({CMD_ERASE, SIZE_ERASE, 8'hFF}), {RSP_ACK});
    st(STAT_SEL, 8'h01);
    xf({CMD_ERASE}, {RSP_CMDERR, CMD_ERASE});
  endtask
  task automatic t_prog();
    bpe_q_t f;
    xf({CMD_SEL_USER}, {RSP_ACK});
    f = {CMD_PROG, 8'h00, 8'h00, 8'h00, 8'h80};
    for (int i = 0; i < 128; i++) f.push_back((i < 100) ? 8'(i) : BYTE_FF);
    xf(wc(f), {RSP_ACK});
    chk("stored", fm.mem[1][8'hC5], 8'h45);
    f[4] = 8'h40;
    xf(wc(f), {RSP_PROG, ERR_ADDR});
    xf(wc({CMD_PROG, 8'hFF, 8'hFF, 8'hFF, 8'hFF}), {RSP_ACK});
    st(STAT_SEL, 8'h01);
    xf({CMD_UBLANK}, {RSP_UBLANK, ERR_BLANK});
    xf({CMD_USUM}, wc({RSP_USUM, SIZE_SUM, 8'h00, 8'h00, 8'hAE, 8'hBA}));
  endtask
  task automatic t_read();
    xf(rdf(8'h01, 32'h80, 32'h2), wc({CMD_READ, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01}));
    xf(rdf(8'h02, 32'h0, 32'h1), {RSP_READ, ERR_ADDR});
    xf(rdf(8'h01, 32'hFF, 32'h2), {RSP_READ, ERR_LEN});
  endtask
  // Undefined command, then every flash failure path except the user-area select
  task automatic t_fault();
    bpe_q_t f;
    xf({8'h00}, {RSP_CMDERR, 8'h00});
    fe = 1'b1;
    xf({CMD_SEL_ERASE}, {RSP_SELE, ERR_SELECT});
    xf({CMD_SEL_BOOT}, {RSP_SELB, ERR_SELECT});
    fe = 1'b0;
    xf({CMD_SEL_ERASE}, {RSP_ACK});
    fe = 1'b1;
    xf(wc({CMD_ERASE, SIZE_ERASE, 8'h02}), {RSP_ERASE, ERR_ERASE});
    fe = 1'b0;
    xf(wc({CMD_ERASE, SIZE_ERASE, 8'hFF}), {RSP_ACK});
    xf({CMD_SEL_USER}, {RSP_ACK});
    f = {CMD_PROG, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 128; i++) f.push_back(BYTE_FF);
    fe = 1'b1;
    xf(wc(f), {RSP_PROG, ERR_PROG});
    fe = 1'b0;
    st(STAT_SEL, 8'h01);
  endtask
  // Mid-run reset from selection wait clears the sticky error flag
  task automatic t_reset();
    rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    st(STAT_SEL, 8'h00);
  endtask
  initial begin
    rst_n = 1'b0;
    rxv = 1'b0;
    rxd = 8'h00;
    txr = 1'b0;
    fe = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_idle();
    t_erase();
    t_prog();
    t_read();
    t_fault();
    t_reset();
    complete_run();
  end
endmodule
bind bpe_handler bpe_chk #(.BOOT_SIZE(BOOT_SIZE), .USER_SIZE(USER_SIZE),
  .NUM_BLOCKS(NUM_BLOCKS)) u_chk (.clk_i, .rst_n_i, .rx_ready_o, .tx_valid_o, .tx_data_o,
  .tx_ready_i, .fl_req_o, .fl_op_o, .fl_area_o, .fl_addr_o, .fl_block_o, .fl_ack_i);
